// File: logic/exc_pkg.sv
// Purpose: shared constants for the request checker and exception reply builder
// Assumes: byte-wide frame stream from a receiver that flags link faults
// Notes: sub-codes and fault codes are the on-wire values
package exc_pkg;
  localparam logic [7:0] FC_READ_HOLD = 8'h03;
  localparam logic [7:0] FC_WRITE_ONE = 8'h06;
  localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
  localparam logic [7:0] EXC_FLAG_MASK = 8'h80;
  localparam logic [7:0] SUB_BAD_FUNC = 8'h01;
  localparam logic [7:0] SUB_BAD_ADDR = 8'h02;
  localparam logic [7:0] SUB_BAD_VALUE = 8'h03;
  localparam logic [7:0] SUB_NAK = 8'h07;
  localparam logic [7:0] FAULT_NONE = 8'h00;
  localparam logic [7:0] FAULT_CRC = 8'h47;
  localparam logic [7:0] FAULT_PARITY = 8'h48;
  localparam logic [7:0] FAULT_OTHER = 8'h49;
  localparam logic [15:0] MAX_REG_COUNT = 16'h0010;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [2:0] REPLY_LEN = 3'h5;
endpackage

// File: logic/exc_crc16.sv
// Purpose: one-byte step of the link check sum
// Assumes: reflected polynomial, low byte sent first
// Notes: purely combinational
`timescale 1ns/1ps
module exc_crc16
  import exc_pkg::*;
(
  // data
  input wire logic [15:0] crc_i,
  input wire logic [7:0] byte_i,
  // result
  output logic [15:0] crc_o
);
  logic [15:0] stage [0:8];
  assign stage[0] = crc_i ^ {8'h00, byte_i};
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_bit
      assign stage[g+1] = stage[g][0] ? ((stage[g] >> 1) ^ CRC_POLY) : (stage[g] >> 1);
    end
  endgenerate
  assign crc_o = stage[8];
endmodule

// File: logic/modbus_rtu_exception_handler.sv
// Purpose: judge each request taken in idle; reply with exception or stay silent
// Assumes: receiver and parameter store on the same clock
// Notes: one judgement per req_valid_i pulse taken in idle; pulses during a reply are not judged
// Contract
// R1 - clean but unserviceable request gets exception reply
// R2 - exception reply carries cause sub-code
// R3 - unknown function code gives sub-code 1
// R4 - unused start address gives sub-code 2
// R5 - span past group end gives sub-code 2
// R6 - more than 16 registers gives sub-code 2
// R7 - out-of-range write data gives sub-code 3
// R8 - write locked while running gives 7
// R9 - write owned by option card gives 7
// R10 - link-faulty frame gets no reply
// R11 - parity, framing, crc are link faults
// R12 - last link fault code kept, overwritten
// R13 - crc 71, parity 72, others 73
// R14 - reply: address, function or 80, sub-code, crc
`timescale 1ns/1ps
module modbus_rtu_exception_handler
  import exc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // decoded request from the frame receiver
  input wire logic req_valid_i,
  input wire logic [7:0] req_slave_i,
  input wire logic [7:0] req_func_i,
  input wire logic [15:0] req_count_i,
  input wire logic req_is_write_i,
  // link fault flags for the same frame
  input wire logic fault_crc_i,
  input wire logic fault_parity_i,
  input wire logic fault_framing_i,
  input wire logic fault_overrun_i,
  input wire logic fault_buffull_i,
  // answers from the parameter store
  input wire logic addr_unused_i,
  input wire logic span_past_end_i,
  input wire logic value_out_of_range_i,
  input wire logic run_locked_i,
  input wire logic drive_running_i,
  input wire logic option_owned_i,
  // outcome
  output logic serve_o,
  output logic write_commit_o,
  output logic [7:0] last_link_fault_code_o,
  // exception reply byte stream
  output logic tx_valid_o,
  output logic [7:0] tx_byte_o,
  output logic tx_last_o,
  output logic busy_o
);

  // ------------------------------------------------
  // judgement
  // ------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_CRC = 3'b100
  } state_t;

  state_t state_ff;
  state_t nxt_state;
  logic link_fault;
  logic func_ok;
  logic addr_bad;
  logic nak;
  logic value_bad;
  logic refuse;
  logic [7:0] sub_code;
  logic [7:0] fault_code;
  logic accept;

  assign link_fault = fault_crc_i | fault_parity_i | fault_framing_i
                    | fault_overrun_i | fault_buffull_i; // R11
  assign func_ok = (req_func_i == FC_READ_HOLD) | (req_func_i == FC_WRITE_ONE)
                 | (req_func_i == FC_WRITE_MULTI);
  assign addr_bad = addr_unused_i // R4
                  | span_past_end_i // R5
                  | (req_count_i > MAX_REG_COUNT); // R6
  assign nak = req_is_write_i & ((run_locked_i & drive_running_i) // R8
             | option_owned_i); // R9
  assign value_bad = req_is_write_i & value_out_of_range_i; // R7
  assign refuse = ~func_ok | addr_bad | value_bad | nak; // R1
  assign sub_code = ~func_ok ? SUB_BAD_FUNC : // R3
                    addr_bad ? SUB_BAD_ADDR :
                    value_bad ? SUB_BAD_VALUE :
                    SUB_NAK; // R2
  assign fault_code = fault_crc_i ? FAULT_CRC :
                      fault_parity_i ? FAULT_PARITY :
                      FAULT_OTHER; // R13
  assign accept = req_valid_i & (state_ff == ST_IDLE);

  // ------------------------------------------------
  // state
  // ------------------------------------------------
  logic [2:0] idx_ff;
  logic [2:0] nxt_idx;
  logic [7:0] slave_ff;
  logic [7:0] func_ff;
  logic [7:0] sub_ff;
  logic [15:0] crc_ff;
  logic [15:0] nxt_crc;
  logic [15:0] crc_step;
  logic [7:0] cur_byte;
  logic [7:0] nxt_tx_byte;
  logic nxt_tx_valid;
  logic nxt_tx_last;

  assign cur_byte = (idx_ff == 3'h0) ? slave_ff :
                    (idx_ff == 3'h1) ? func_ff : sub_ff;

  exc_crc16 u_crc (
    .crc_i(crc_ff),
    .byte_i(cur_byte),
    .crc_o(crc_step)
  );

  always_comb
  begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_crc = crc_ff;
    nxt_tx_valid = 1'b0;
    nxt_tx_byte = 8'h00;
    nxt_tx_last = 1'b0;
    case (state_ff)
      ST_IDLE:
      begin
        if (accept && !link_fault && refuse)
        begin
          nxt_state = ST_SEND;
          nxt_idx = 3'h0;
          nxt_crc = CRC_INIT;
        end
      end
      ST_SEND:
      begin
        nxt_tx_valid = 1'b1; // R14
        nxt_tx_byte = cur_byte;
        nxt_crc = crc_step;
        nxt_idx = idx_ff + 3'h1;
        if (idx_ff == 3'h2)
        begin
          nxt_state = ST_CRC;
        end
      end
      ST_CRC:
      begin
        nxt_tx_valid = 1'b1;
        nxt_idx = idx_ff + 3'h1;
        if (idx_ff == 3'h3)
        begin
          nxt_tx_byte = crc_ff[7:0];
        end
        else
        begin
          nxt_tx_byte = crc_ff[15:8];
          nxt_tx_last = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      state_ff <= ST_IDLE;
      idx_ff <= 3'h0;
      crc_ff <= CRC_INIT;
      slave_ff <= 8'h00;
      func_ff <= 8'h00;
      sub_ff <= 8'h00;
      tx_valid_o <= 1'b0;
      tx_byte_o <= 8'h00;
      tx_last_o <= 1'b0;
      busy_o <= 1'b0;
      serve_o <= 1'b0;
      write_commit_o <= 1'b0;
      last_link_fault_code_o <= FAULT_NONE;
    end
    else
    begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      crc_ff <= nxt_crc;
      tx_valid_o <= nxt_tx_valid;
      tx_byte_o <= nxt_tx_byte;
      tx_last_o <= nxt_tx_last;
      busy_o <= (nxt_state != ST_IDLE);
      serve_o <= accept & ~link_fault & ~refuse; // R10
      write_commit_o <= accept & ~link_fault & ~refuse & req_is_write_i; // R7
      if (accept && !link_fault && refuse)
      begin
        slave_ff <= req_slave_i;
        func_ff <= req_func_i | EXC_FLAG_MASK; // R14
        sub_ff <= sub_code;
      end
      if (req_valid_i && link_fault)
      begin
        last_link_fault_code_o <= fault_code; // R12
      end
    end
  end

  // ------------------------------------------------
  // checks: link faults
  // ------------------------------------------------
  a_silent_on_fault: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R10
    (accept && link_fault)
    |=> !serve_o && !write_commit_o && !busy_o ##1 !tx_valid_o)
    else $error("reply started after link fault");
  a_parity_silent: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R11
    (accept && fault_parity_i) |=> !busy_o && !serve_o)
    else $error("parity fault not silent");
  a_fault_code_kept: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R12
    (req_valid_i && fault_crc_i) |=> last_link_fault_code_o == FAULT_CRC)
    else $error("crc fault code not recorded");
  a_parity_code: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R13
    (req_valid_i && !fault_crc_i && fault_parity_i) |=> last_link_fault_code_o == FAULT_PARITY)
    else $error("parity fault code wrong");
  a_other_code: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R13
    (req_valid_i && !fault_crc_i && !fault_parity_i && fault_framing_i)
    |=> last_link_fault_code_o == FAULT_OTHER)
    else $error("framing fault code wrong");
  a_overrun_code: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R13
    (req_valid_i && !fault_crc_i && !fault_parity_i && (fault_overrun_i || fault_buffull_i))
    |=> last_link_fault_code_o == FAULT_OTHER)
    else $error("overrun or buffer fault code wrong");
  a_fault_code_held: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R12
    !(req_valid_i && link_fault) |=> $stable(last_link_fault_code_o))
    else $error("fault code changed without a fault");

  // ------------------------------------------------
  // checks: refusal
  // ------------------------------------------------
  a_bad_func_sub: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R3
    (accept && !link_fault && !func_ok) |=> ##3 tx_valid_o && tx_byte_o == SUB_BAD_FUNC)
    else $error("illegal function sub-code wrong");
  a_unused_addr: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R4
    (accept && !link_fault && func_ok && addr_unused_i)
    |=> ##3 tx_valid_o && tx_byte_o == SUB_BAD_ADDR)
    else $error("unused address sub-code wrong");
  a_span_end: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R5
    (accept && !link_fault && func_ok && span_past_end_i)
    |=> ##3 tx_valid_o && tx_byte_o == SUB_BAD_ADDR)
    else $error("span past group end sub-code wrong");
  a_count_limit: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R6
    (accept && !link_fault && func_ok && req_count_i > MAX_REG_COUNT)
    |=> ##3 tx_byte_o == SUB_BAD_ADDR)
    else $error("count limit sub-code wrong");
  a_value_sub: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R7
    (accept && !link_fault && func_ok && !addr_bad && value_bad)
    |=> ##3 tx_valid_o && tx_byte_o == SUB_BAD_VALUE)
    else $error("out-of-range value sub-code wrong");
  a_value_no_commit: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R7
    (accept && value_bad) |=> !write_commit_o)
    else $error("out-of-range write committed");
  a_nak_running: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R8
    (accept && !link_fault && func_ok && !addr_bad && !value_bad && nak)
    |=> ##3 tx_byte_o == SUB_NAK)
    else $error("nak sub-code wrong");
  a_option_nak: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R9
    (accept && !link_fault && func_ok && !addr_bad && !value_bad && option_owned_i
     && req_is_write_i)
    |=> ##3 tx_valid_o && tx_byte_o == SUB_NAK)
    else $error("option owned write not refused");
  a_no_serve_refused: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R1
    (accept && refuse) |=> !serve_o && !write_commit_o)
    else $error("refused request was served");
  a_commit_clean: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R7
    write_commit_o |-> serve_o)
    else $error("write committed without service");
  a_write_gated: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R7
    (accept && !req_is_write_i) |=> !write_commit_o)
    else $error("read request committed a write");

  // ------------------------------------------------
  // checks: reply framing
  // ------------------------------------------------
  a_slave_echo: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R14
    (accept && !link_fault && refuse)
    |=> ##1 tx_valid_o && tx_byte_o == $past(req_slave_i, 2))
    else $error("slave address echo wrong");
  a_func_echo: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R14
    (accept && !link_fault && refuse)
    |=> ##2 tx_valid_o && tx_byte_o == ($past(req_func_i, 3) | EXC_FLAG_MASK))
    else $error("function echo wrong");
  a_reply_len: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R1
    (accept && !link_fault && refuse) |=> ##1 tx_valid_o [*5] ##0 tx_last_o)
    else $error("exception reply length wrong");
  a_reply_busy: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R1
    (accept && !link_fault && refuse) |=> busy_o [*5] ##1 !busy_o)
    else $error("busy does not cover the reply");
  a_last_in_frame: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R14
    tx_last_o |-> tx_valid_o)
    else $error("last flag without a byte");
endmodule

// File: dv/rtu_master_model.sv
// Purpose: master side model that collects exception reply bytes
// Assumes: one reply at a time
// Notes: clr_i empties the store before each request
`timescale 1ns/1ps
module rtu_master_model
(
  // clock and control
  input wire logic sys_clk_i,
  input wire logic clr_i,
  // reply stream
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic tx_last_i,
  // collected reply
  output logic [3:0] rx_cnt_o,
  output logic [4:0][7:0] rx_byte_o,
  output logic rx_last_o
);
  always_ff @(posedge sys_clk_i)
  begin
    if (clr_i)
    begin
      rx_cnt_o <= 4'h0;
      rx_last_o <= 1'b0;
    end
    else if (tx_valid_i)
    begin
      if (rx_cnt_o < 4'h5)
        rx_byte_o[rx_cnt_o[2:0]] <= tx_byte_i;
      rx_cnt_o <= rx_cnt_o + 4'h1;
      rx_last_o <= tx_last_i;
    end
  end
endmodule

// File: dv/modbus_rtu_exception_handler_tb_top.sv
// Purpose: self-checking bench for the exception handler
// Assumes: reply done within 8 cycles of the take edge
// Notes: master requests stay within 16 registers unless refused on purpose
`timescale 1ns/1ps
module modbus_rtu_exception_handler_tb_top
  import exc_pkg::*;
;
  logic clk, rstn, rv, wr, clr, srv_o, cm_o, txv, txl, busy, rx_last, srv, cm, bsy;
  logic [7:0] slv, fn, code, txb;
  logic [4:0][7:0] rx_b;
  logic [3:0] rx_cnt;
  logic [15:0] cnt;
  logic [5:0] st;
  logic [4:0] lf;
  int mismatches, check_count;
  modbus_rtu_exception_handler i_modbus_rtu_exception_handler (
    .sys_clk_i(clk), .rstn_i(rstn), .req_valid_i(rv), .req_slave_i(slv),
    .req_func_i(fn), .req_count_i(cnt), .req_is_write_i(wr),
    .fault_crc_i(lf[4]), .fault_parity_i(lf[3]), .fault_framing_i(lf[2]),
    .fault_overrun_i(lf[1]), .fault_buffull_i(lf[0]),
    .addr_unused_i(st[5]), .span_past_end_i(st[4]), .value_out_of_range_i(st[3]),
    .run_locked_i(st[2]), .drive_running_i(st[1]), .option_owned_i(st[0]),
    .serve_o(srv_o), .write_commit_o(cm_o), .last_link_fault_code_o(code),
    .tx_valid_o(txv), .tx_byte_o(txb), .tx_last_o(txl), .busy_o(busy));
  rtu_master_model i_rtu_master_model (
    .sys_clk_i(clk), .clr_i(clr), .tx_valid_i(txv), .tx_byte_i(txb),
    .tx_last_i(txl), .rx_cnt_o(rx_cnt), .rx_byte_o(rx_b), .rx_last_o(rx_last));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction
  task automatic run(input logic [7:0] f, input logic [15:0] n, input logic w,
                     input logic [5:0] s, input logic [4:0] l);
    @(posedge clk);
    rv <= 1'b1;
    fn <= f;
    cnt <= n;
    wr <= w;
    st <= s;
    lf <= l;
    clr <= 1'b1;
    @(posedge clk);
    rv <= 1'b0;
    clr <= 1'b0;
    srv = 1'b0;
    cm = 1'b0;
    bsy = 1'b0;
    repeat (8)
    begin
      #1;
      srv = srv | srv_o;
      cm = cm | cm_o;
      bsy = bsy | busy;
      @(posedge clk);
    end
    #1;
    cmp("busy", 16'h0000, {15'h0000, busy});
  endtask
  task automatic exc(input logic [7:0] f, input logic [15:0] n, input logic w,
                     input logic [5:0] s, input logic [7:0] sub);
    logic [15:0] c;
    run(f, n, w, s, 5'h00);
    c = crc_step(crc_step(crc_step(CRC_INIT, slv), f | EXC_FLAG_MASK), sub);
    cmp("reply count", 16'h0005, {12'h000, rx_cnt});
    cmp("busy seen", 16'h0001, {15'h0000, bsy});
    cmp("reply slave", {8'h00, slv}, {8'h00, rx_b[0]});
    cmp("reply func", {8'h00, f | EXC_FLAG_MASK}, {8'h00, rx_b[1]});
    cmp("reply sub", {8'h00, sub}, {8'h00, rx_b[2]});
    cmp("reply crc", c, {rx_b[4], rx_b[3]});
    cmp("reply last", 16'h0001, {15'h0000, rx_last});
    cmp("serve commit", 16'h0000, {14'h0000, srv, cm});
  endtask
  task automatic served(input logic [7:0] f, input logic [15:0] n, input logic w,
                        input logic [5:0] s);
    run(f, n, w, s, 5'h00);
    cmp("reply count", 16'h0000, {12'h000, rx_cnt});
    cmp("busy seen", 16'h0000, {15'h0000, bsy});
    cmp("serve commit", {14'h0000, 1'b1, w}, {14'h0000, srv, cm});
  endtask
  task automatic t_func();
    served(FC_READ_HOLD, 16'h0010, 1'b0, 6'h00);
    served(FC_WRITE_ONE, 16'h0001, 1'b1, 6'h00);
    served(FC_WRITE_MULTI, 16'h0002, 1'b1, 6'h00);
    exc(8'h04, 16'h0001, 1'b0, 6'h00, SUB_BAD_FUNC);
    exc(8'h05, 16'h0001, 1'b1, 6'h20, SUB_BAD_FUNC);
    $display("test func done");
  endtask
  task automatic t_addr();
    exc(FC_READ_HOLD, 16'h0001, 1'b0, 6'h20, SUB_BAD_ADDR);
    exc(FC_WRITE_MULTI, 16'h0002, 1'b1, 6'h18, SUB_BAD_ADDR);
    exc(FC_READ_HOLD, 16'h0011, 1'b0, 6'h00, SUB_BAD_ADDR);
    $display("test addr done");
  endtask
  task automatic t_write();
    exc(FC_WRITE_ONE, 16'h0001, 1'b1, 6'h0f, SUB_BAD_VALUE);
    exc(FC_WRITE_MULTI, 16'h0002, 1'b1, 6'h06, SUB_NAK);
    served(FC_WRITE_ONE, 16'h0001, 1'b1, 6'h04);
    exc(FC_WRITE_ONE, 16'h0001, 1'b1, 6'h01, SUB_NAK);
    served(FC_READ_HOLD, 16'h0001, 1'b0, 6'h0f);
    $display("test write done");
  endtask
  task automatic t_fault();
    logic [7:0] fc;
    for (int i = 0; i < 5; i++)
    begin
      run(i[0] ? 8'h05 : FC_READ_HOLD, 16'h0001, 1'b0, 6'h20, 5'h10 >> i);
      fc = (i == 0) ? FAULT_CRC : ((i == 1) ? FAULT_PARITY : FAULT_OTHER);
      cmp("silent", 16'h0000, {11'h000, rx_cnt, srv});
      cmp("fault code", {8'h00, fc}, {8'h00, code});
    end
    served(FC_READ_HOLD, 16'h0001, 1'b0, 6'h00);
    cmp("fault code kept", {8'h00, FAULT_OTHER}, {8'h00, code});
    run(FC_READ_HOLD, 16'h0001, 1'b0, 6'h00, 5'h18);
    cmp("fault code new", {8'h00, FAULT_CRC}, {8'h00, code});
    $display("test fault done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    {rstn, rv, wr, clr, st, lf, cnt, fn} = '0;
    slv = 8'h11;
    mismatches = 0;
    check_count = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    #1;
    cmp("fault code reset", {8'h00, FAULT_NONE}, {8'h00, code});
    t_func();
    t_addr();
    t_write();
    t_fault();
    tally_and_finish();
  end
endmodule
